// >>> src/dpi_pkg.sv
package dpi_pkg;
  // Command field widths
  localparam int ROW_W  = 15;
  localparam int COL_W  = 10;
  localparam int ADDR_W = 17;
  // Address bit positions with extra meaning
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  // Mode register numbers and fields used here
  localparam logic [2:0] MR_TERM  = 3'h1;
  localparam logic [2:0] MR_CRC   = 3'h2;
  localparam logic [2:0] MR_VREF  = 3'h4;
  localparam logic [2:0] MR_PARDM = 3'h5;
  localparam int MR1_NOM_LSB  = 8;
  localparam int MR2_CRC_BIT  = 12;
  localparam int MR4_VREF_BIT = 4;
  localparam int MR5_PAR_BIT  = 0;
  localparam int MR5_DM_BIT   = 10;
  localparam int MR5_WDBI_BIT = 11;
  localparam int MR5_RDBI_BIT = 12;
  // Alert timing, in device clocks
  localparam int CRC_ALERT_CYC = 6;
  localparam int PAR_ALERT_CYC = 48;
  localparam logic [5:0] ALERT_CNT_RST = 6'h00;
  // Burst lengths in beats
  localparam logic [3:0] BURST_FULL = 4'h8;
  localparam logic [3:0] BURST_CHOP = 4'h4;

  typedef enum {
    DPI_ST_IDLE, DPI_ST_ACTIVE, DPI_ST_PPD, DPI_ST_APD, DPI_ST_SREF
  } dpi_pwr_e;

  typedef enum {
    DPI_CMD_NOP, DPI_CMD_ACT, DPI_CMD_RD, DPI_CMD_WR, DPI_CMD_PRE,
    DPI_CMD_MRS, DPI_CMD_REF, DPI_CMD_ZQ, DPI_CMD_DES
  } dpi_cmd_e;

  // Sampled command/address pins
  typedef struct packed {
    logic              cs_n;
    logic              act_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic              bg;
    logic [1:0]        ba;
    logic [ADDR_W-1:0] addr;
    logic              par;
  } dpi_ca_s;

  // Decoded access presented to the core
  typedef struct packed {
    logic             rd;
    logic             wr;
    logic [2:0]       bank;
    logic [COL_W-1:0] col;
    logic             auto_pre;
    logic [3:0]       beats;
  } dpi_acc_s;
endpackage

// >>> src/dpi_pin_if.sv
`timescale 1ns/1ps
// Functional notes
// - Sample command and address only on rising edge of the link clock.
// - CKE low enters precharge/active power-down by bank state, or self-refresh with a refresh command when idle.
// - Power-down and self-refresh both keep clock and CKE buffers; exit waits for a link clock edge.
// - Chip select high masks the command; it is part of the code.
// - ODT high terminates all data pins unless nominal termination disabled.
// - ACT low with select decodes activate; WE pin becomes the top row bit.
// - Write beats with mask low are not stored; mask taken on both edges.
// - Mode register five picks mask or inversion for the shared pin.
// - Inversion pin low means byte is inverted; device restores it.
// - Bank group and bank pick bank, or mode register for a set.
// - Row fifteen bits, column ten bits, opcode from address on set.
// - Address bit ten on read/write requests auto-precharge.
// - Precharge with bit ten low closes one bank, high closes all.
// - Address bit twelve low chops the burst, high runs full burst.
// - Reset pin low holds device in reset regardless of clock.
// - Write CRC, when enabled, follows last data beat.
// - Vref test mode drives reference level on a low data pin.
// - Strobes differential; lower pair serves low byte, upper high byte.
// - Even parity over command, bank and address checked when enabled.
// - CRC error pulses alert low briefly; parity error holds it longer.
module dpi_pin_if
  import dpi_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Pins from the controller
  input  wire logic        ck_t_i,
  input  wire logic        ck_c_i,
  input  wire logic        cke_i,
  input  wire logic        reset_pin_n_i,
  input  wire logic        odt_i,
  input  wire logic        ten_i,
  input  wire dpi_ca_s     ca_i,
  // Write data, per beat, with strobe edge marker
  input  wire logic        wbeat_i,
  input  wire logic [15:0] dq_i,
  input  wire logic [1:0]  dmi_n_i,
  input  wire logic        crc_err_i,
  // Read data from the core
  input  wire logic        rbeat_i,
  input  wire logic [15:0] rdata_i,
  // Alert pin, open drain
  input  wire logic        alert_n_i,
  output logic             alert_n_o,
  output logic             alert_oe_n_o,
  // Data pins out
  output logic [15:0]      dq_o,
  output logic [1:0]       dmi_n_o,
  output logic             dq_oe_n_o,
  output logic [1:0]       dqs_t_o,
  output logic [1:0]       dqs_c_o,
  // Status and core side
  output dpi_acc_s         acc_o,
  output logic [15:0]      wdata_o,
  output logic [1:0]       wstore_o,
  output logic             term_on_o,
  output logic             vref_mon_o,
  output logic             crc_en_o,
  output logic [1:0]       pwr_o,
  output logic [7:0]       open_o,
  output logic [ROW_W-1:0] row_o,
  output logic             ten_o
);
  // Two-flop sync of clock, control and command pins; the first stage feeds only the second
  logic [6:0]  s1_ff, s2_ff;
  dpi_ca_s     ca1_ff, ca2_ff;
  logic        ck_d_ff;
  always_ff @(posedge clk_i) begin
    s1_ff   <= {ck_t_i, ck_c_i, cke_i, reset_pin_n_i, odt_i, ten_i, alert_n_i};
    s2_ff   <= s1_ff;
    ca1_ff  <= ca_i;
    ca2_ff  <= ca1_ff;
    ck_d_ff <= s2_ff[6] & ~s2_ff[5];
  end
  // Crossing taken only after both clock legs are synchronised
  wire ck_rise = s2_ff[6] & ~s2_ff[5] & ~ck_d_ff;
  wire cke_s   = s2_ff[4];
  wire rst_all = reset_i | ~s2_ff[3];
  wire odt_s   = s2_ff[2];
  wire ten_s   = s2_ff[1];
  wire alert_s = s2_ff[0];

  // State registers
  dpi_pwr_e    pwr_ff, nxt_pwr;
  logic [7:0]  open_ff, nxt_open;
  logic [ADDR_W-1:0] mr1_ff, mr2_ff, mr4_ff, mr5_ff;
  logic [ADDR_W-1:0] nxt_mr1, nxt_mr2, nxt_mr4, nxt_mr5;
  dpi_acc_s    acc_ff, nxt_acc;
  logic [5:0]  alert_cnt_ff, nxt_alert_cnt;
  logic        odt_ff, nxt_odt;
  logic [ROW_W-1:0] row_ff, nxt_row;
  logic        par_err;
  dpi_cmd_e    cmd;

  // Command decode; select high masks everything
  always_comb begin
    cmd = DPI_CMD_NOP;
    if (ca2_ff.cs_n) cmd = DPI_CMD_DES;
    else if (!ca2_ff.act_n) cmd = DPI_CMD_ACT;
    else begin
      unique case ({ca2_ff.ras_n, ca2_ff.cas_n, ca2_ff.we_n})
        3'h0: cmd = DPI_CMD_MRS;
        3'h1: cmd = DPI_CMD_REF;
        3'h2: cmd = DPI_CMD_PRE;
        3'h3: cmd = DPI_CMD_NOP;
        3'h4: cmd = DPI_CMD_WR;
        3'h5: cmd = DPI_CMD_RD;
        3'h6: cmd = DPI_CMD_ZQ;
        3'h7: cmd = DPI_CMD_NOP;
      endcase
    end
  end

  // Even parity over command, bank and A15..A0
  assign par_err = mr5_ff[MR5_PAR_BIT] & ~ca2_ff.cs_n &
    (^{ca2_ff.act_n, ca2_ff.ras_n, ca2_ff.cas_n, ca2_ff.we_n, ca2_ff.bg,
       ca2_ff.ba, ca2_ff.addr[15:0], ca2_ff.par});

  // Commands and ODT are ignored in power-down and self-refresh; CKE, reset pin and parity alert still act
  wire in_lp  = (pwr_ff == DPI_ST_PPD) | (pwr_ff == DPI_ST_APD) |
                (pwr_ff == DPI_ST_SREF);
  wire cmd_ok = ck_rise & ~in_lp & ~par_err;
  wire [2:0] bank = {ca2_ff.bg, ca2_ff.ba};

  // Next-state for bank, mode registers, power and access
  always_comb begin
    nxt_pwr  = pwr_ff;
    nxt_open = open_ff;
    nxt_mr1  = mr1_ff;
    nxt_mr2  = mr2_ff;
    nxt_mr4  = mr4_ff;
    nxt_mr5  = mr5_ff;
    nxt_acc  = acc_ff;
    nxt_odt  = odt_ff;
    nxt_row  = row_ff;
    nxt_acc.rd = 1'b0;
    nxt_acc.wr = 1'b0;
    if (cmd_ok) begin
      unique case (cmd)
        DPI_CMD_ACT: begin
          nxt_open[bank] = 1'b1;
          nxt_row        = {ca2_ff.we_n, ca2_ff.addr[ROW_W-2:0]};
        end
        DPI_CMD_PRE: begin
          if (ca2_ff.addr[AP_BIT]) nxt_open = 8'h00;
          else nxt_open[bank] = 1'b0;
        end
        DPI_CMD_RD, DPI_CMD_WR: begin
          nxt_acc.rd       = (cmd == DPI_CMD_RD);
          nxt_acc.wr       = (cmd == DPI_CMD_WR);
          nxt_acc.bank     = bank;
          nxt_acc.col      = ca2_ff.addr[COL_W-1:0];
          nxt_acc.auto_pre = ca2_ff.addr[AP_BIT];
          nxt_acc.beats    = ca2_ff.addr[BC_BIT] ? BURST_FULL : BURST_CHOP;
          if (ca2_ff.addr[AP_BIT]) nxt_open[bank] = 1'b0;
        end
        DPI_CMD_MRS: begin
          unique case (bank)
            MR_TERM:  nxt_mr1 = ca2_ff.addr;
            MR_CRC:   nxt_mr2 = ca2_ff.addr;
            MR_VREF:  nxt_mr4 = ca2_ff.addr;
            MR_PARDM: nxt_mr5 = ca2_ff.addr;
            default:  nxt_mr1 = mr1_ff;
          endcase
        end
        default: nxt_open = open_ff;
      endcase
    end
    // CKE is sampled on the clock edge; self-refresh exit is synchronous too
    if (ck_rise) begin
      if (!cke_s) begin
        if (pwr_ff == DPI_ST_IDLE)
          nxt_pwr = (cmd == DPI_CMD_REF) ? DPI_ST_SREF : DPI_ST_PPD;
        else if (pwr_ff == DPI_ST_ACTIVE) nxt_pwr = DPI_ST_APD;
      end else if (in_lp) begin
        // Leaving power-down keeps track of banks that stayed open
        nxt_pwr = (open_ff != 8'h00) ? DPI_ST_ACTIVE : DPI_ST_IDLE;
      end else begin
        nxt_pwr = (nxt_open != 8'h00) ? DPI_ST_ACTIVE : DPI_ST_IDLE;
      end
    end
    // ODT is registered on the link clock like the command pins
    if (ck_rise && !in_lp) nxt_odt = odt_s;
  end

  // Alert counter: CRC short pulse, parity long hold
  always_comb begin
    nxt_alert_cnt = alert_cnt_ff;
    if (par_err && ck_rise) nxt_alert_cnt = 6'(PAR_ALERT_CYC);
    else if (crc_err_i && alert_cnt_ff == ALERT_CNT_RST)
      nxt_alert_cnt = 6'(CRC_ALERT_CYC);
    else if (alert_cnt_ff != ALERT_CNT_RST) nxt_alert_cnt = alert_cnt_ff - 6'h01;
  end

  // Register all state groups; reset pin acts through the synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      pwr_ff       <= DPI_ST_IDLE;
      open_ff      <= 8'h00;
      mr1_ff       <= '0;
      mr2_ff       <= '0;
      mr4_ff       <= '0;
      mr5_ff       <= '0;
      acc_ff       <= '0;
      alert_cnt_ff <= ALERT_CNT_RST;
      odt_ff       <= 1'b0;
      row_ff       <= '0;
    end else begin
      pwr_ff       <= nxt_pwr;
      open_ff      <= nxt_open;
      mr1_ff       <= nxt_mr1;
      mr2_ff       <= nxt_mr2;
      mr4_ff       <= nxt_mr4;
      mr5_ff       <= nxt_mr5;
      acc_ff       <= nxt_acc;
      alert_cnt_ff <= nxt_alert_cnt;
      odt_ff       <= nxt_odt;
      row_ff       <= nxt_row;
    end
  end

  // Write data path: mask or inversion on each byte lane
  logic [15:0] wdata_ff, nxt_wdata;
  logic [1:0]  wstore_ff, nxt_wstore;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_lane
      always_comb begin
        nxt_wdata[g*8 +: 8] = dq_i[g*8 +: 8];
        nxt_wstore[g] = wbeat_i;
        if (mr5_ff[MR5_WDBI_BIT] && !dmi_n_i[g])
          nxt_wdata[g*8 +: 8] = ~dq_i[g*8 +: 8];
        else if (mr5_ff[MR5_DM_BIT] && !dmi_n_i[g])
          nxt_wstore[g] = 1'b0;
      end
    end
  endgenerate

  // Read path: invert a byte when more than half its bits are zero
  logic [15:0] dq_ff, nxt_dq;
  logic [1:0]  dmi_ff, nxt_dmi;
  logic        oe_n_ff, nxt_oe_n;
  logic [1:0]  dqs_ff, nxt_dqs;
  generate
    for (g = 0; g < 2; g++) begin : g_rd
      logic [3:0] ones;
      always_comb begin
        ones = '0;
        for (int b = 0; b < 8; b++) ones = ones + 4'(rdata_i[g*8+b]);
        nxt_dq[g*8 +: 8] = rdata_i[g*8 +: 8];
        nxt_dmi[g] = 1'b1;
        if (mr5_ff[MR5_RDBI_BIT] && ones < 4'h4) begin
          nxt_dq[g*8 +: 8] = ~rdata_i[g*8 +: 8];
          nxt_dmi[g] = 1'b0;
        end
        nxt_dqs[g] = rbeat_i & ~dqs_ff[g];
      end
    end
  endgenerate
  assign nxt_oe_n = ~rbeat_i;

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      wdata_ff  <= '0;
      wstore_ff <= '0;
      dq_ff     <= '0;
      dmi_ff    <= 2'h3;
      oe_n_ff   <= 1'b1;
      dqs_ff    <= '0;
    end else begin
      wdata_ff  <= nxt_wdata;
      wstore_ff <= nxt_wstore;
      dq_ff     <= nxt_dq;
      dmi_ff    <= nxt_dmi;
      oe_n_ff   <= nxt_oe_n;
      dqs_ff    <= nxt_dqs;
    end
  end

  // Outputs; alert is open drain and floats in connectivity test
  assign alert_n_o    = 1'b0;
  assign alert_oe_n_o = ten_s | (alert_cnt_ff == ALERT_CNT_RST);
  assign ten_o        = ten_s & ~alert_s;
  assign dq_o         = dq_ff;
  assign dmi_n_o      = dmi_ff;
  assign dq_oe_n_o    = oe_n_ff;
  assign dqs_t_o      = dqs_ff;
  assign dqs_c_o      = ~dqs_ff;
  assign acc_o        = acc_ff;
  assign wdata_o      = wdata_ff;
  assign wstore_o     = wstore_ff;
  assign term_on_o    = odt_ff & (mr1_ff[MR1_NOM_LSB +: 3] != 3'h0);
  assign vref_mon_o   = mr4_ff[MR4_VREF_BIT];
  assign crc_en_o     = mr2_ff[MR2_CRC_BIT];
  assign pwr_o        = {in_lp, pwr_ff == DPI_ST_SREF};
  assign open_o       = open_ff;
  assign row_o        = row_ff;

  // Checks
  property p_chop;
    @(posedge clk_i) disable iff (rst_all)
      cmd_ok && cmd == DPI_CMD_RD && !ca2_ff.addr[BC_BIT] |=> acc_ff.beats == BURST_CHOP;
  endproperty
  burst_chop_a: assert property (p_chop) else $error("chop beats wrong");
  pre_all_a: assert property (@(posedge clk_i) disable iff (rst_all)
    cmd_ok && cmd == DPI_CMD_PRE && ca2_ff.addr[AP_BIT] |=> open_ff == 8'h00)
    else $error("precharge all failed");
  desel_a: assert property (@(posedge clk_i) disable iff (rst_all)
    ca2_ff.cs_n |=> !acc_ff.rd && !acc_ff.wr) else $error("deselect not masked");
  act_open_a: assert property (@(posedge clk_i) disable iff (rst_all)
    cmd_ok && cmd == DPI_CMD_ACT |=> open_ff[$past(bank)]) else $error("bank not opened");
  auto_pre_a: assert property (@(posedge clk_i) disable iff (rst_all)
    cmd_ok && cmd == DPI_CMD_WR && ca2_ff.addr[AP_BIT] |=> acc_ff.auto_pre && !open_ff[acc_ff.bank])
    else $error("auto precharge missed");
  par_alert_a: assert property (@(posedge clk_i) disable iff (rst_all)
    par_err && ck_rise && !ten_s |=> !alert_oe_n_o [*8]) else $error("parity alert short");
  mask_a: assert property (@(posedge clk_i) disable iff (rst_all)
    wbeat_i && mr5_ff[MR5_DM_BIT] && !mr5_ff[MR5_WDBI_BIT] && !dmi_n_i[0] |=> !wstore_ff[0])
    else $error("masked beat stored");
  lp_block_a: assert property (@(posedge clk_i) disable iff (rst_all)
    in_lp |=> !acc_ff.rd && !acc_ff.wr) else $error("command taken in low power");
  odt_a: assert property (@(posedge clk_i) disable iff (rst_all)
    mr1_ff[MR1_NOM_LSB +: 3] == 3'h0 |-> !term_on_o) else $error("odt not ignored");
  cov_rd: cover property (@(posedge clk_i) acc_ff.rd);
  cov_sref: cover property (@(posedge clk_i) pwr_ff == DPI_ST_SREF);
  cov_alert: cover property (@(posedge clk_i) !alert_oe_n_o);
endmodule

// >>> tb/dpi_ctrl_model.sv
`timescale 1ns/1ps
// Stand-in for the memory controller: link clock and command pins
module dpi_ctrl_model
  import dpi_pkg::*;
(
  // Link clock and command pins
  output logic    ck_t_o,
  output logic    ck_c_o,
  output dpi_ca_s ca_o
);
  // Clock stands still and chip is deselected between frames
  initial begin
    ck_t_o = 1'h0;
    ck_c_o = 1'h1;
    ca_o   = '1;
  end

  // Even parity over command, bank and low address bits
  function automatic logic even_par(input dpi_ca_s c);
    return ^{c.act_n, c.ras_n, c.cas_n, c.we_n, c.bg, c.ba, c.addr[15:0]};
  endfunction

  // One command per 800 ns link clock; bad flips parity on purpose
  task automatic send(input dpi_ca_s c, input logic bad);
    c.par = even_par(c) ^ bad;
    ca_o = c;
    #400;
    ck_t_o = 1'h1;
    ck_c_o = 1'h0;
    #400;
    ck_t_o = 1'h0;
    ck_c_o = 1'h1;
    // Hold time over: pins no longer show the old command
    c = ~c;
    c.cs_n = 1'h1;
    ca_o = c;
  endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench
  import dpi_pkg::*;
;
  logic        clk_i, reset_i, cke_i, reset_pin_n_i, odt_i, ten_i, alert_ext, alert_w;
  logic        wbeat_i, crc_err_i, rbeat_i, ck_t, ck_c, alert_n_o, alert_oe_n_o;
  logic        dq_oe_n_o, term_on_o, vref_mon_o, crc_en_o, ten_o, hit;
  logic [15:0] dq_i, rdata_i, dq_o, wdata_o;
  logic [1:0]  dmi_n_i, dmi_n_o, dqs_t_o, dqs_c_o, wstore_o, pwr_o;
  logic [7:0]  open_o;
  logic [14:0] row_o;
  logic [31:0] seed;
  dpi_ca_s     ca;
  dpi_acc_s    acc_o, a;
  int          n_mismatch, check_count, run_cnt, alert_run;

  dpi_ctrl_model ctl (.ck_t_o(ck_t), .ck_c_o(ck_c), .ca_o(ca));

  // Open-drain alert line with pull-up
  assign alert_w = (alert_oe_n_o === 1'h0) ? 1'h0 : alert_ext;

  dpi_pin_if dut (.clk_i(clk_i), .reset_i(reset_i), .ck_t_i(ck_t), .ck_c_i(ck_c),
    .cke_i(cke_i), .reset_pin_n_i(reset_pin_n_i), .odt_i(odt_i), .ten_i(ten_i), .ca_i(ca),
    .wbeat_i(wbeat_i), .dq_i(dq_i), .dmi_n_i(dmi_n_i), .crc_err_i(crc_err_i),
    .rbeat_i(rbeat_i), .rdata_i(rdata_i), .alert_n_i(alert_w), .alert_n_o(alert_n_o),
    .alert_oe_n_o(alert_oe_n_o), .dq_o(dq_o), .dmi_n_o(dmi_n_o), .dq_oe_n_o(dq_oe_n_o),
    .dqs_t_o(dqs_t_o), .dqs_c_o(dqs_c_o), .acc_o(acc_o), .wdata_o(wdata_o),
    .wstore_o(wstore_o), .term_on_o(term_on_o), .vref_mon_o(vref_mon_o),
    .crc_en_o(crc_en_o), .pwr_o(pwr_o), .open_o(open_o), .row_o(row_o),
    .ten_o(ten_o));

  // 100 ns system clock
  initial begin
    clk_i = 1'h0;
    forever #50 clk_i = ~clk_i;
  end

  // Length of the most recent alert pulse, in clocks
  always @(posedge clk_i) begin
    if (alert_oe_n_o === 1'h0) begin
      run_cnt <= run_cnt + 1;
    end else if (run_cnt != 0) begin
      alert_run <= run_cnt;
      run_cnt   <= 0;
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected decode of a read or write
  function automatic dpi_acc_s exp_acc(input logic w, input logic [2:0] b,
                                       input logic [16:0] ad);
    return {~w, w, b, ad[COL_W-1:0], ad[AP_BIT], ad[BC_BIT] ? BURST_FULL : BURST_CHOP};
  endfunction

  // Expected read lanes with inversion: {inversion pins, data}
  function automatic logic [17:0] exp_dbi(input logic [15:0] d);
    logic [17:0] e;
    e = {2'h3, d};
    for (int l = 0; l < 2; l++) begin
      if ($countones(d[l*8 +: 8]) < 4) begin
        e[16+l] = 1'h0;
        e[l*8 +: 8] = ~d[l*8 +: 8];
      end
    end
    return e;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Fixed window long enough for sync latency; also proves refusals
  task automatic watch();
    hit = 1'h0;
    a = '0;
    repeat (16) begin
      tick(1);
      if (acc_o.rd === 1'h1 || acc_o.wr === 1'h1) begin
        hit = 1'h1;
        a = acc_o;
      end
    end
  endtask

  task automatic cmd(input logic [3:0] op, input logic [2:0] b, input logic [16:0] ad,
                     input logic cs_n, input logic bad);
    fork
      ctl.send({cs_n, op, b, ad, 1'h0}, bad);
      watch();
    join
  endtask

  task automatic beat(input logic [15:0] d, input logic [1:0] m);
    dq_i = d;
    dmi_n_i = m;
    wbeat_i = 1'h1;
    tick(1);
    wbeat_i = 1'h0;
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    logic [31:0] r;
    logic [16:0] ad;
    // Reset pin and clock enable kept high in normal use
    {reset_i, reset_pin_n_i, cke_i, alert_ext} = 4'hF;
    {odt_i, ten_i, wbeat_i, crc_err_i, rbeat_i} = 5'h00;
    dq_i = 16'h0000;
    rdata_i = 16'h0000;
    dmi_n_i = 2'h3;
    seed = 32'h25A4;
    n_mismatch = 0;
    check_count = 0;
    run_cnt = 0;
    alert_run = 0;
    tick(3);
    reset_i = 1'h0;
    tick(4);
    // Random reads and writes, last one at column edge with chop and auto-precharge
    for (int i = 0; i < 10; i++) begin
      r = rnd();
      ad = (i == 9) ? 17'h007FF : r[16:0];
      cmd(r[20] ? 4'hC : 4'hD, r[23:21], ad, 1'h0, 1'h0);
      chk("acc", exp_acc(r[20], r[23:21], ad), a);
    end
    cmd(4'hD, 3'h1, 17'h00000, 1'h1, 1'h0);
    chk("desel", 1'h0, hit);
    // Activate with NOP-like bits on the row pins still opens the bank
    cmd(4'h0, 3'h2, 17'h00000, 1'h0, 1'h0);
    cmd(4'h7, 3'h5, 17'h1ABCD, 1'h0, 1'h0);
    chk("open", 8'h24, open_o);
    chk("row", 15'h6BCD, row_o);
    cmd(4'hA, 3'h2, 17'h00000, 1'h0, 1'h0);
    chk("open", 8'h20, open_o);
    cmd(4'h0, 3'h0, 17'h00000, 1'h0, 1'h0);
    cmd(4'hA, 3'h0, 17'h00400, 1'h0, 1'h0);
    chk("open", 8'h00, open_o);
    cmd(4'h0, 3'h3, 17'h00000, 1'h0, 1'h0);
    reset_pin_n_i = 1'h0;
    tick(4);
    reset_pin_n_i = 1'h1;
    tick(4);
    chk("open", 8'h00, open_o);
    // Termination on, off with ODT low, ignored once disabled; CRC and Vref bits set
    odt_i = 1'h1;
    cmd(4'h8, MR_TERM, 17'h00100, 1'h0, 1'h0);
    chk("term", 1'h1, term_on_o);
    odt_i = 1'h0;
    cmd(4'h8, MR_CRC, 17'h01000, 1'h0, 1'h0);
    chk("term", 1'h0, term_on_o);
    odt_i = 1'h1;
    cmd(4'h8, MR_TERM, 17'h00000, 1'h0, 1'h0);
    chk("term", 1'h0, term_on_o);
    odt_i = 1'h0;
    cmd(4'h8, MR_VREF, 17'h00010, 1'h0, 1'h0);
    chk("crc_en", 1'h1, crc_en_o);
    chk("vref", 1'h1, vref_mon_o);
    // Mask mode, then write inversion mode
    cmd(4'h8, MR_PARDM, 17'h00400, 1'h0, 1'h0);
    r = rnd();
    beat(r[15:0], 2'h1);
    chk("wstore", 2'h1, wstore_o);
    cmd(4'h8, MR_PARDM, 17'h00800, 1'h0, 1'h0);
    beat(r[15:0], 2'h2);
    chk("wdata", {r[15:8], ~r[7:0]}, wdata_o);
    chk("wstore", 2'h3, wstore_o);
    rdata_i = r[31:16];
    rbeat_i = 1'h1;
    tick(1);
    rbeat_i = 1'h0;
    chk("dq_o", r[31:16], dq_o);
    chk("dq_oe", 1'h0, dq_oe_n_o);
    chk("dqs", 4'hC, {dqs_t_o, dqs_c_o});
    // Read inversion; four ones is the boundary that stays true
    cmd(4'h8, MR_PARDM, 17'h01000, 1'h0, 1'h0);
    rbeat_i = 1'h1;
    for (int j = 0; j < 4; j++) begin
      r = rnd();
      rdata_i = (j == 0) ? 16'h0F01 : r[15:0];
      tick(1);
      chk("rdbi", exp_dbi(rdata_i), {dmi_n_o, dq_o});
    end
    rbeat_i = 1'h0;
    // Parity on: bad command refused with long alert, good one taken
    cmd(4'h8, MR_PARDM, 17'h00001, 1'h0, 1'h0);
    cmd(4'hD, 3'h1, 17'h00000, 1'h0, 1'h1);
    chk("badpar", 1'h0, hit);
    tick(60);
    chk("par_alert", PAR_ALERT_CYC, alert_run);
    cmd(4'hD, 3'h1, 17'h00000, 1'h0, 1'h0);
    chk("goodpar", 1'h1, hit);
    crc_err_i = 1'h1;
    tick(1);
    crc_err_i = 1'h0;
    tick(12);
    chk("crc_alert", CRC_ALERT_CYC, alert_run);
    ten_i = 1'h1;
    alert_ext = 1'h0;
    tick(2);
    chk("ten", 1'h1, ten_o);
    chk("alert_n", 1'h0, alert_n_o);
    ten_i = 1'h0;
    alert_ext = 1'h1;
    // Precharge power-down, self-refresh, active power-down; each left with clock enable high
    for (int k = 0; k < 3; k++) begin
      if (k == 2) cmd(4'h0, 3'h6, 17'h00000, 1'h0, 1'h0);
      cke_i = 1'h0;
      cmd((k == 1) ? 4'h9 : 4'hD, 3'h1, 17'h00000, (k == 1) ? 1'h0 : 1'h1, 1'h0);
      chk("pwr", (k == 1) ? 2'h3 : 2'h2, pwr_o);
      cmd(4'hD, 3'h1, 17'h00000, 1'h0, 1'h0);
      chk("lp_rd", 1'h0, hit);
      cke_i = 1'h1;
      cmd(4'hD, 3'h1, 17'h00000, 1'h1, 1'h0);
      chk("pwr", 2'h0, pwr_o);
    end
    print_verdict();
  end
endmodule
